//--- hw/vic_pkg.sv
// vic_pkg: constants shared by the vectored interrupt controller files.
// assumes an 8-bit core with 16-bit addresses and a downward-growing stack.
package vic_pkg;
   localparam int unsigned VIC_NUM_SLOTS = 14;
   localparam int unsigned VIC_NUM_EXT = 4;
   localparam int unsigned VIC_NUM_PERIPH = 6;
   // vector addresses
   localparam logic [15:0] VIC_VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VIC_VEC_TRAP = 16'hFFFC;
   localparam logic [15:0] VIC_VEC_SLOT0 = 16'hFFFA;
   // slot numbers
   localparam logic [3:0] VIC_SLOT_EXT0 = 4'h1;
   localparam logic [3:0] VIC_SLOT_AVD = 4'h7;
   localparam logic [3:0] VIC_SLOT_AT_CMP = 4'h8;
   localparam logic [3:0] VIC_SLOT_AT_OVF = 4'h9;
   localparam logic [3:0] VIC_SLOT_LT_CAP = 4'hA;
   localparam logic [3:0] VIC_SLOT_LT_TB = 4'hB;
   localparam logic [3:0] VIC_SLOT_SPI = 4'hC;
   localparam logic [4:0] VIC_TRAP_CODE = 5'h1E;
   // slots that may leave stop mode: 1-4, 9, 11, 12
   localparam logic [13:0] VIC_STOP_WAKE_MASK = 14'h1A1E;
   // peripheral order on the flag ports, index -> slot
   localparam logic [23:0] VIC_PERIPH_SLOTS = 24'hCBA987;
   // sensitivity encodings
   localparam logic [1:0] VIC_SENS_FALL_LOW = 2'h0;
   localparam logic [1:0] VIC_SENS_RISE = 2'h1;
   localparam logic [1:0] VIC_SENS_FALL = 2'h2;
   localparam logic [1:0] VIC_SENS_BOTH = 2'h3;
   localparam logic [7:0] VIC_SENS_RESET = 8'h00;
   // context: pch, pcl, x, a, cc
   localparam logic [2:0] VIC_CTX_BYTES = 3'h5;
   localparam logic [7:0] VIC_SP_RESET = 8'hFF;
   typedef enum logic [5:0] {
      VIC_IDLE = 6'b000001,
      VIC_PUSH = 6'b000010,
      VIC_VECT = 6'b000100,
      VIC_RUN = 6'b001000,
      VIC_POP = 6'b010000,
      VIC_DONE = 6'b100000
   } vic_state_t;
endpackage : vic_pkg

//--- hw/vic_ext_line.sv
// vic_ext_line: one external interrupt line with selectable sensitivity.
// assumes the pin is synchronous to the clock and sampled each cycle.
`timescale 1ns/100ps
module vic_ext_line
   import vic_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pin and setting
   input wire logic pin,
   input wire logic pin_gate_n,
   input wire logic [1:0] sens,
   input wire logic sens_changed,
   // service
   input wire logic ack,
   output logic req
);
   logic pin_q;
   logic latch_q;
   logic pin_eff;
   logic rise;
   logic fall;
   logic edge_hit;
   // low on the gate input holds the effective pin low, blocking rising edges; low level mode then requests
   assign pin_eff = pin & pin_gate_n;
   assign rise = pin_eff & ~pin_q;
   assign fall = ~pin_eff & pin_q;
   always_comb begin
      case (sens)
         VIC_SENS_FALL_LOW: edge_hit = fall;
         VIC_SENS_RISE: edge_hit = rise;
         VIC_SENS_FALL: edge_hit = fall;
         VIC_SENS_BOTH: edge_hit = rise | fall;
         default: edge_hit = 1'b0;
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_q <= 1'b1;
      end else begin
         pin_q <= pin_eff;
      end
   end
   // new edge wins over service clear; setting change discards it
   always_ff @(posedge clk) begin
      if (srst) begin
         latch_q <= 1'b0;
      end else if (sens_changed) begin
         latch_q <= 1'b0;
      end else if (edge_hit) begin
         latch_q <= 1'b1;
      end else if (ack) begin
         latch_q <= 1'b0;
      end
   end
   // low level mode requests while the pin stays low, unlatched
   assign req = latch_q | ((sens == VIC_SENS_FALL_LOW) & ~pin_eff & ~sens_changed);
endmodule : vic_ext_line

//--- hw/vic_top.sv
// vic_top: prioritised vectored interrupt controller with context sequencer.
// assumes the core raises INSTR_END at each instruction boundary and
// performs stack writes and reads named by the sequencer one per STACK_ACK.
// Notes on behaviour
// - maskable requests serviced only with mask clear
// - global mask set after any reset
// - entry waits for current instruction end
// - entry pushes program counter, index, accumulator, flags
// - entry sets the global mask bit
// - load program counter from winning vector
// - return restores context and clears mask
// - fixed priority: reset, trap, ascending slots
// - any request wakes wait mode
// - only listed sources wake stop mode
// - trap enters regardless of mask
// - edge latches clear when the core takes the vector
// - low gate input forces the combined pin low
// - peripheral raises only enabled and unmasked
// - clear sequence discards the pending latch
// - two-byte vectors descending from reset vector
// - fixed slot assignment for sources
// - two-bit sensitivity per external line
// - sensitivity change clears pending line request
// - sensitivity writes accepted only while masked
// - five stack bytes, pointer moves per byte
`timescale 1ns/100ps
module vic_top
   import vic_pkg::*;
#(
   parameter int unsigned NUM_PERIPH = VIC_NUM_PERIPH
)
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic SRST,
   // core handshake
   input wire logic INSTR_END,
   input wire logic TRAP_EXEC,
   input wire logic RETURN_EXEC,
   input wire logic VECTOR_ACK,
   input wire logic STACK_ACK,
   input wire logic WAIT_MODE,
   input wire logic STOP_MODE,
   // core context
   input wire logic [15:0] PROGRAM_COUNTER_IN,
   input wire logic [7:0] INDEX_IN,
   input wire logic [7:0] ACCUM_IN,
   input wire logic [7:0] CONDITION_CODE_IN,
   input wire logic [7:0] STACK_RDATA,
   // mask control from software
   input wire logic MASK_SET,
   input wire logic MASK_CLR,
   // external lines
   input wire logic [VIC_NUM_EXT-1:0] EXT_PIN,
   input wire logic [VIC_NUM_EXT-1:0] EXT_GATE_N,
   input wire logic SENS_WR,
   input wire logic [7:0] SENS_WDATA,
   // peripheral flags, enables and clear sequence strobes
   input wire logic [NUM_PERIPH-1:0] PERIPH_FLAG,
   input wire logic [NUM_PERIPH-1:0] PERIPH_EN,
   input wire logic [NUM_PERIPH-1:0] PERIPH_CLR,
   // outputs to core
   output logic IRQ_REQ,
   output logic [3:0] IRQ_SLOT,
   output logic IRQ_IS_TRAP,
   output logic [15:0] VECTOR_ADDR,
   output logic MASK_BIT,
   output logic SUSPEND,
   output logic STACK_WE,
   output logic STACK_RE,
   output logic [7:0] STACK_ADDR,
   output logic [7:0] STACK_WDATA,
   output logic [15:0] PROGRAM_COUNTER_OUT,
   output logic [7:0] INDEX_OUT,
   output logic [7:0] ACCUM_OUT,
   output logic [7:0] CONDITION_CODE_OUT,
   output logic RESTORE_VALID,
   output logic WAKE_WAIT,
   output logic WAKE_STOP,
   output logic [7:0] SENS_CFG
);
   vic_state_t state_q;
   logic mask_q;
   logic [7:0] sens_q;
   logic [7:0] sp_q;
   logic [2:0] cnt_q;
   logic [39:0] ctx_q;
   logic [3:0] slot_q;
   logic trap_q;
   logic trap_pend_q;
   logic req_q;
   logic [NUM_PERIPH-1:0] periph_pend_q;
   logic [VIC_NUM_EXT-1:0] ext_req;
   logic [VIC_NUM_EXT-1:0] ext_ack;
   logic [VIC_NUM_EXT-1:0] sens_chg;
   logic [VIC_NUM_SLOTS-1:0] slot_pend;
   logic [VIC_NUM_SLOTS-1:0] slot_live;
   logic any_live;
   logic [3:0] win_slot;
   logic sens_wr_ok;
   logic entry_go;

   // vector of a slot: two bytes each, descending
   function automatic logic [15:0] slot_vector(input logic [3:0] s);
      slot_vector = VIC_VEC_SLOT0 - {11'h000, s, 1'b0};
   endfunction : slot_vector

   function automatic logic [3:0] periph_slot(input int unsigned i);
      periph_slot = VIC_PERIPH_SLOTS[i*4 +: 4];
   endfunction : periph_slot

   assign sens_wr_ok = SENS_WR & mask_q;

   genvar g;
   generate
      for (g = 0; g < VIC_NUM_EXT; g++) begin : g_ext
         assign sens_chg[g] = sens_wr_ok & (SENS_WDATA[g*2 +: 2] != sens_q[g*2 +: 2]);
         assign ext_ack[g] = VECTOR_ACK & req_q & ~trap_q & (slot_q == VIC_SLOT_EXT0 + 4'(g));
         vic_ext_line u_line (
            .clk(REF_CLK),
            .srst(SRST),
            .pin(EXT_PIN[g]),
            .pin_gate_n(EXT_GATE_N[g]),
            .sens(sens_q[g*2 +: 2]),
            .sens_changed(sens_chg[g]),
            .ack(ext_ack[g]),
            .req(ext_req[g])
         );
      end
      // peripheral pending register: follows the flag each cycle, clear sequence discards it
      for (g = 0; g < NUM_PERIPH; g++) begin : g_per
         always_ff @(posedge REF_CLK) begin
            if (SRST) begin
               periph_pend_q[g] <= 1'b0;
            end else if (PERIPH_CLR[g]) begin
               periph_pend_q[g] <= 1'b0;
            end else begin
               periph_pend_q[g] <= PERIPH_FLAG[g];
            end
         end
      end
   endgenerate

   // map sources to slots
   always_comb begin
      slot_pend = '0;
      slot_live = '0;
      for (int i = 0; i < VIC_NUM_EXT; i++) begin
         slot_pend[VIC_SLOT_EXT0 + 4'(i)] = ext_req[i];
      end
      for (int i = 0; i < NUM_PERIPH; i++) begin
         slot_pend[periph_slot(i)] = periph_pend_q[i] & PERIPH_EN[i];
      end
      slot_live = slot_pend & {VIC_NUM_SLOTS{~mask_q}};
   end

   // lowest slot number wins
   always_comb begin
      win_slot = 4'h0;
      any_live = 1'b0;
      for (int i = VIC_NUM_SLOTS - 1; i >= 0; i--) begin
         if (slot_live[i]) begin
            win_slot = 4'(i);
            any_live = 1'b1;
         end
      end
   end

   // trap held until its entry starts
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         trap_pend_q <= 1'b0;
      end else if (TRAP_EXEC) begin
         trap_pend_q <= 1'b1;
      end else if (entry_go && trap_pend_q) begin
         trap_pend_q <= 1'b0;
      end
   end

   assign entry_go = (state_q == VIC_IDLE) & INSTR_END & (trap_pend_q | any_live);

   // global mask bit
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         mask_q <= 1'b1;
      end else if (entry_go) begin
         mask_q <= 1'b1;
      end else if (state_q == VIC_DONE) begin
         mask_q <= 1'b0;
      end else if (MASK_SET) begin
         mask_q <= 1'b1;
      end else if (MASK_CLR) begin
         mask_q <= 1'b0;
      end
   end

   // sensitivity settings
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         sens_q <= VIC_SENS_RESET;
      end else if (sens_wr_ok) begin
         sens_q <= SENS_WDATA;
      end
   end

   // sequencer: push, vector, run, pop
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         state_q <= VIC_IDLE;
         cnt_q <= 3'h0;
         sp_q <= VIC_SP_RESET;
         ctx_q <= '0;
         slot_q <= 4'h0;
         trap_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         case (state_q)
            VIC_IDLE: begin
               if (entry_go) begin
                  // trap outranks all maskable slots
                  trap_q <= trap_pend_q;
                  slot_q <= trap_pend_q ? 4'h0 : win_slot;
                  ctx_q <= {PROGRAM_COUNTER_IN, INDEX_IN, ACCUM_IN, CONDITION_CODE_IN};
                  cnt_q <= VIC_CTX_BYTES;
                  state_q <= VIC_PUSH;
               end else if (RETURN_EXEC) begin
                  cnt_q <= VIC_CTX_BYTES;
                  sp_q <= sp_q + 8'h01;
                  state_q <= VIC_POP;
               end
            end
            VIC_PUSH: begin
               if (STACK_ACK) begin
                  ctx_q <= {ctx_q[31:0], 8'h00};
                  cnt_q <= cnt_q - 3'h1;
                  sp_q <= sp_q - 8'h01;
                  if (cnt_q == 3'h1) begin
                     req_q <= 1'b1;
                     state_q <= VIC_VECT;
                  end
               end
            end
            VIC_VECT: begin
               // held stable until the core takes the vector
               if (VECTOR_ACK) begin
                  req_q <= 1'b0;
                  state_q <= VIC_RUN;
               end
            end
            VIC_RUN: begin
               state_q <= VIC_IDLE;
            end
            VIC_POP: begin
               if (STACK_ACK) begin
                  ctx_q <= {ctx_q[31:0], STACK_RDATA};
                  cnt_q <= cnt_q - 3'h1;
                  if (cnt_q == 3'h1) begin
                     state_q <= VIC_DONE;
                  end else begin
                     sp_q <= sp_q + 8'h01;
                  end
               end
            end
            VIC_DONE: begin
               state_q <= VIC_IDLE;
            end
            default: begin
               state_q <= VIC_IDLE;
            end
         endcase
      end
   end

   // registered outputs
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         IRQ_REQ <= 1'b0;
         IRQ_SLOT <= 4'h0;
         IRQ_IS_TRAP <= 1'b0;
         VECTOR_ADDR <= VIC_VEC_RESET;
         MASK_BIT <= 1'b1;
         SUSPEND <= 1'b0;
         SENS_CFG <= VIC_SENS_RESET;
      end else begin
         IRQ_REQ <= req_q & ~(VECTOR_ACK & (state_q == VIC_VECT));
         IRQ_SLOT <= slot_q;
         IRQ_IS_TRAP <= trap_q;
         // keeps the reset vector until a first request is presented
         VECTOR_ADDR <= ~req_q ? VECTOR_ADDR : (trap_q ? VIC_VEC_TRAP : slot_vector(slot_q));
         MASK_BIT <= mask_q;
         SUSPEND <= (state_q == VIC_PUSH) | (state_q == VIC_VECT) | (state_q == VIC_POP) | entry_go;
         SENS_CFG <= sens_q;
      end
   end

   // stack port: pushed order pch, pcl, x, a, cc; popped in reverse
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         STACK_WE <= 1'b0;
         STACK_RE <= 1'b0;
         STACK_ADDR <= VIC_SP_RESET;
         STACK_WDATA <= 8'h00;
      end else begin
         STACK_WE <= (state_q == VIC_PUSH) & ~(STACK_ACK & (cnt_q == 3'h1));
         STACK_RE <= (state_q == VIC_POP) & ~(STACK_ACK & (cnt_q == 3'h1));
         STACK_ADDR <= (state_q == VIC_PUSH && STACK_ACK) ? sp_q - 8'h01 :
                       (state_q == VIC_POP && STACK_ACK) ? sp_q + 8'h01 :
                       (state_q == VIC_IDLE && RETURN_EXEC) ? sp_q + 8'h01 : sp_q;
         STACK_WDATA <= (state_q == VIC_PUSH && STACK_ACK) ? ctx_q[31:24] :
                        (entry_go ? PROGRAM_COUNTER_IN[15:8] : ctx_q[39:32]);
      end
   end

   // restored context, cc first popped lowest, pc last
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         PROGRAM_COUNTER_OUT <= 16'h0000;
         INDEX_OUT <= 8'h00;
         ACCUM_OUT <= 8'h00;
         CONDITION_CODE_OUT <= 8'h00;
         RESTORE_VALID <= 1'b0;
      end else begin
         RESTORE_VALID <= (state_q == VIC_DONE);
         if (state_q == VIC_DONE) begin
            CONDITION_CODE_OUT <= ctx_q[39:32] & ~8'h08;
            ACCUM_OUT <= ctx_q[31:24];
            INDEX_OUT <= ctx_q[23:16];
            PROGRAM_COUNTER_OUT <= {ctx_q[7:0], ctx_q[15:8]};
         end
      end
   end

   // wake: wait on any pending, stop only on listed sources, trap excluded
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         WAKE_WAIT <= 1'b0;
         WAKE_STOP <= 1'b0;
      end else begin
         WAKE_WAIT <= WAIT_MODE & (|slot_pend | trap_pend_q);
         WAKE_STOP <= STOP_MODE & (|(slot_pend & VIC_STOP_WAKE_MASK));
      end
   end
endmodule : vic_top

//--- verif/vic_top_chk.sv
// vic_top_chk: port-level assertions for the interrupt controller.
// assumes it is bound to vic_top and sees only its ports.
`timescale 1ns/100ps
module vic_top_chk
   import vic_pkg::*;
#(
   parameter int unsigned NUM_PERIPH = VIC_NUM_PERIPH
)
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic SRST,
   // core side inputs
   input wire logic INSTR_END,
   input wire logic VECTOR_ACK,
   input wire logic STACK_ACK,
   input wire logic SENS_WR,
   input wire logic [7:0] SENS_WDATA,
   // observed outputs
   input wire logic IRQ_REQ,
   input wire logic [3:0] IRQ_SLOT,
   input wire logic IRQ_IS_TRAP,
   input wire logic [15:0] VECTOR_ADDR,
   input wire logic MASK_BIT,
   input wire logic SUSPEND,
   input wire logic STACK_WE,
   input wire logic STACK_RE,
   input wire logic [7:0] STACK_ADDR,
   input wire logic [7:0] CONDITION_CODE_OUT,
   input wire logic RESTORE_VALID,
   input wire logic WAKE_STOP,
   input wire logic [7:0] SENS_CFG
);
   logic [2:0] push_cnt_q;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   // pushes counted per entry, cleared once the vector is taken
   always_ff @(posedge REF_CLK) begin
      if (SRST || (IRQ_REQ && VECTOR_ACK)) begin
         push_cnt_q <= 3'h0;
      end else if (STACK_WE && STACK_ACK) begin
         push_cnt_q <= push_cnt_q + 3'h1;
      end
   end
   a_req_held: assert property (IRQ_REQ && !VECTOR_ACK |=> IRQ_REQ && $stable(IRQ_SLOT) && $stable(VECTOR_ADDR))
      else $error("request or slot moved before vector ack");
   a_req_drops: assert property (IRQ_REQ && VECTOR_ACK |=> !IRQ_REQ)
      else $error("request stayed after vector ack");
   a_slot_vector: assert property (IRQ_REQ && !IRQ_IS_TRAP |-> VECTOR_ADDR == VIC_VEC_SLOT0 - {11'h0, IRQ_SLOT, 1'b0})
      else $error("vector address does not match slot");
   a_trap_vector: assert property (IRQ_REQ && IRQ_IS_TRAP |-> VECTOR_ADDR == VIC_VEC_TRAP && IRQ_SLOT == 4'h0)
      else $error("trap vector wrong");
   a_mask_entry: assert property ($rose(IRQ_REQ) |-> MASK_BIT)
      else $error("mask not set on entry");
   // return also raises suspend, together with the first pop strobe
   a_entry_cause: assert property ($rose(SUSPEND) && !STACK_RE |-> $past(INSTR_END))
      else $error("suspend without instruction end");
   a_push_five: assert property ($rose(IRQ_REQ) |-> push_cnt_q == VIC_CTX_BYTES)
      else $error("context push count wrong");
   a_sp_step: assert property (STACK_WE && STACK_ACK |=> STACK_ADDR == $past(STACK_ADDR) - 8'h01)
      else $error("stack pointer did not step down");
   // the setting output trails the internal register by one cycle
   a_sens_refused: assert property (SENS_WR && !MASK_BIT |=> ##1 $stable(SENS_CFG))
      else $error("sensitivity changed while unmasked");
   a_sens_taken: assert property (SENS_WR && MASK_BIT |=> ##1 SENS_CFG == $past(SENS_WDATA, 2))
      else $error("sensitivity write lost");
   a_restore_cc: assert property (RESTORE_VALID |-> !CONDITION_CODE_OUT[3] ##1 !MASK_BIT)
      else $error("restored flags keep mask");
   c_trap: cover property ($rose(IRQ_REQ) && IRQ_IS_TRAP);
   c_restore: cover property (RESTORE_VALID);
   c_stop_wake: cover property ($rose(WAKE_STOP));
   c_slow_push: cover property (STACK_WE && !STACK_ACK);
endmodule : vic_top_chk

bind vic_top vic_top_chk #(.NUM_PERIPH(NUM_PERIPH)) u_chk (.REF_CLK(REF_CLK), .SRST(SRST), .INSTR_END(INSTR_END),
   .VECTOR_ACK(VECTOR_ACK), .STACK_ACK(STACK_ACK), .SENS_WR(SENS_WR), .SENS_WDATA(SENS_WDATA), .IRQ_REQ(IRQ_REQ),
   .IRQ_SLOT(IRQ_SLOT), .IRQ_IS_TRAP(IRQ_IS_TRAP), .VECTOR_ADDR(VECTOR_ADDR), .MASK_BIT(MASK_BIT), .SUSPEND(SUSPEND),
   .STACK_WE(STACK_WE), .STACK_RE(STACK_RE), .STACK_ADDR(STACK_ADDR), .CONDITION_CODE_OUT(CONDITION_CODE_OUT),
   .RESTORE_VALID(RESTORE_VALID), .WAKE_STOP(WAKE_STOP), .SENS_CFG(SENS_CFG));

//--- verif/vic_core_model.sv
// vic_core_model: core stack and vector fetch side, behavioural.
// assumes one byte per ack; slow mode adds wait states.
`timescale 1ns/100ps
module vic_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic slow,
   // stack byte port
   input wire logic stack_we,
   input wire logic stack_re,
   input wire logic [7:0] stack_addr,
   input wire logic [7:0] stack_wdata,
   output logic stack_ack,
   output logic [7:0] stack_rdata,
   // vector fetch
   input wire logic irq_req,
   output logic vector_ack
);
   logic [7:0] mem_q [256];
   logic [1:0] wait_q;
   logic [1:0] vwait_q;
   assign stack_ack = (stack_we || stack_re) && (wait_q == (slow ? 2'h2 : 2'h0));
   // idle bus shows inverted data, never the stale byte
   assign stack_rdata = stack_re ? mem_q[stack_addr] : ~mem_q[stack_addr];
   assign vector_ack = irq_req && (vwait_q == (slow ? 2'h3 : 2'h1));
   always_ff @(posedge clk) begin
      if (srst || !(stack_we || stack_re) || stack_ack) begin
         wait_q <= 2'h0;
      end else begin
         wait_q <= wait_q + 2'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (stack_we && stack_ack) begin
         mem_q[stack_addr] <= stack_wdata;
      end
   end
   always_ff @(posedge clk) begin
      if (srst || !irq_req || vector_ack) begin
         vwait_q <= 2'h0;
      end else begin
         vwait_q <= vwait_q + 2'h1;
      end
   end
endmodule : vic_core_model

//--- verif/test_vectored_interrupt_controller.sv
// test_vectored_interrupt_controller: self-checking bench for vic_top.
// assumes vic_core_model answers stack and vector fetches.
`timescale 1ns/100ps
module test_vectored_interrupt_controller;
   import vic_pkg::*;
   logic REF_CLK = 1'b0, SRST = 1'b1, INSTR_END = 1'b0, TRAP_EXEC = 1'b0, RETURN_EXEC = 1'b0, slow = 1'b0;
   logic WAIT_MODE = 1'b0, STOP_MODE = 1'b0, MASK_SET = 1'b0, MASK_CLR = 1'b0, SENS_WR = 1'b0;
   logic [15:0] PROGRAM_COUNTER_IN = 16'h0000;
   logic [7:0] INDEX_IN = 8'h00, ACCUM_IN = 8'h00, CONDITION_CODE_IN = 8'h00, SENS_WDATA = 8'h00;
   logic [3:0] EXT_PIN = 4'hF, EXT_GATE_N = 4'hF;
   logic [5:0] PERIPH_FLAG = 6'h00, PERIPH_EN = 6'h00, PERIPH_CLR = 6'h00;
   logic VECTOR_ACK, STACK_ACK, IRQ_REQ, IRQ_IS_TRAP, MASK_BIT, SUSPEND, STACK_WE, STACK_RE, RESTORE_VALID;
   logic WAKE_WAIT, WAKE_STOP;
   logic [3:0] IRQ_SLOT;
   logic [15:0] VECTOR_ADDR, PROGRAM_COUNTER_OUT;
   logic [7:0] STACK_ADDR, STACK_WDATA, STACK_RDATA, INDEX_OUT, ACCUM_OUT, CONDITION_CODE_OUT, SENS_CFG;
   logic [31:0] seed = 32'h00015B87;
   int err_count = 0;
   int checked = 0;
   logic [7:0] byte_q [$];
   logic [4:0] slot_q [$];
   logic [39:0] rest_q [$];

   always #10 REF_CLK = ~REF_CLK;

   vic_top u_dut (.REF_CLK(REF_CLK), .SRST(SRST), .INSTR_END(INSTR_END), .TRAP_EXEC(TRAP_EXEC),
      .RETURN_EXEC(RETURN_EXEC), .VECTOR_ACK(VECTOR_ACK), .STACK_ACK(STACK_ACK), .WAIT_MODE(WAIT_MODE),
      .STOP_MODE(STOP_MODE), .PROGRAM_COUNTER_IN(PROGRAM_COUNTER_IN), .INDEX_IN(INDEX_IN), .ACCUM_IN(ACCUM_IN),
      .CONDITION_CODE_IN(CONDITION_CODE_IN), .STACK_RDATA(STACK_RDATA), .MASK_SET(MASK_SET), .MASK_CLR(MASK_CLR),
      .EXT_PIN(EXT_PIN), .EXT_GATE_N(EXT_GATE_N), .SENS_WR(SENS_WR), .SENS_WDATA(SENS_WDATA),
      .PERIPH_FLAG(PERIPH_FLAG), .PERIPH_EN(PERIPH_EN), .PERIPH_CLR(PERIPH_CLR), .IRQ_REQ(IRQ_REQ),
      .IRQ_SLOT(IRQ_SLOT), .IRQ_IS_TRAP(IRQ_IS_TRAP), .VECTOR_ADDR(VECTOR_ADDR), .MASK_BIT(MASK_BIT),
      .SUSPEND(SUSPEND), .STACK_WE(STACK_WE), .STACK_RE(STACK_RE), .STACK_ADDR(STACK_ADDR),
      .STACK_WDATA(STACK_WDATA), .PROGRAM_COUNTER_OUT(PROGRAM_COUNTER_OUT), .INDEX_OUT(INDEX_OUT),
      .ACCUM_OUT(ACCUM_OUT), .CONDITION_CODE_OUT(CONDITION_CODE_OUT), .RESTORE_VALID(RESTORE_VALID),
      .WAKE_WAIT(WAKE_WAIT), .WAKE_STOP(WAKE_STOP), .SENS_CFG(SENS_CFG));
   vic_core_model u_core (.clk(REF_CLK), .srst(SRST), .slow(slow), .stack_we(STACK_WE), .stack_re(STACK_RE),
      .stack_addr(STACK_ADDR), .stack_wdata(STACK_WDATA), .stack_ack(STACK_ACK), .stack_rdata(STACK_RDATA),
      .irq_req(IRQ_REQ), .vector_ack(VECTOR_ACK));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   task automatic step(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask : step

   // bounded wait: vector taken, or context restored
   task automatic await(input bit restore);
      int n;
      for (n = 0; n < 200; n++) begin
         @(posedge REF_CLK);
         if (restore ? RESTORE_VALID === 1'b1 : (IRQ_REQ === 1'b1 && VECTOR_ACK === 1'b1)) break;
      end
      if (n == 200) begin
         err_count++;
         final_report();
      end
   endtask : await

   task automatic tick_end();
      @(posedge REF_CLK);
      INSTR_END <= 1'b1;
      @(posedge REF_CLK);
      INSTR_END <= 1'b0;
      step(3);
   endtask : tick_end

   task automatic mask(input bit set);
      @(posedge REF_CLK);
      MASK_SET <= set;
      MASK_CLR <= !set;
      @(posedge REF_CLK);
      MASK_SET <= 1'b0;
      MASK_CLR <= 1'b0;
      step(1);
   endtask : mask

   task automatic sens(input logic [7:0] d);
      @(posedge REF_CLK);
      SENS_WDATA <= d;
      SENS_WR <= 1'b1;
      @(posedge REF_CLK);
      SENS_WR <= 1'b0;
      step(2);
   endtask : sens

   // random context per entry; expected bytes, slot and restore are queued first
   task automatic enter(input logic [3:0] slot, input bit trap);
      logic [31:0] r;
      logic [31:0] s;
      logic [7:0] cc;
      r = rnd();
      s = rnd();
      cc = {s[7:4], trap, s[2:0]};
      byte_q.push_back(r[15:8]);
      byte_q.push_back(r[7:0]);
      byte_q.push_back(r[23:16]);
      byte_q.push_back(r[31:24]);
      byte_q.push_back(cc);
      slot_q.push_back({trap, slot});
      rest_q.push_back({r[15:0], r[23:16], r[31:24], cc & 8'hF7});
      @(posedge REF_CLK);
      TRAP_EXEC <= trap;
      slow <= s[8];
      PROGRAM_COUNTER_IN <= r[15:0];
      INDEX_IN <= r[23:16];
      ACCUM_IN <= r[31:24];
      CONDITION_CODE_IN <= cc;
      @(posedge REF_CLK);
      TRAP_EXEC <= 1'b0;
      INSTR_END <= 1'b1;
      @(posedge REF_CLK);
      INSTR_END <= 1'b0;
      await(1'b0);
   endtask : enter

   task automatic leave();
      step(2);
      RETURN_EXEC <= 1'b1;
      @(posedge REF_CLK);
      RETURN_EXEC <= 1'b0;
      await(1'b1);
      step(2);
   endtask : leave

   always @(posedge REF_CLK) begin
      if (!SRST && STACK_WE && STACK_ACK) begin
         check("stack byte", STACK_WDATA, byte_q.pop_front());
      end
      if (!SRST && IRQ_REQ && VECTOR_ACK) begin
         check("slot", {IRQ_IS_TRAP, IRQ_SLOT}, slot_q.pop_front());
      end
      if (!SRST && RESTORE_VALID) begin
         check("restore", {PROGRAM_COUNTER_OUT, INDEX_OUT, ACCUM_OUT, CONDITION_CODE_OUT}, rest_q.pop_front());
      end
   end

   initial begin
      logic [7:0] d;
      int m;
      repeat (8) @(posedge REF_CLK);
      SRST <= 1'b0;
      step(2);
      check("mask", MASK_BIT, 1'b1);
      check("req", IRQ_REQ, 1'b0);
      check("vector", VECTOR_ADDR, VIC_VEC_RESET);
      check("sens", SENS_CFG, VIC_SENS_RESET);
      d = 8'(rnd());
      sens(d);
      check("sens masked", SENS_CFG, d);
      mask(1'b0);
      sens(~d);
      check("sens unmasked", SENS_CFG, d);
      mask(1'b1);
      enter(4'h0, 1'b1);
      leave();
      // every sensitivity mode on line one
      for (m = 0; m < 4; m++) begin
         mask(1'b1);
         EXT_PIN[1] <= (m != 1);
         sens(8'(m << 2));
         EXT_PIN[1] <= (m == 1);
         tick_end();
         check("masked entry", SUSPEND, 1'b0);
         mask(1'b0);
         enter(4'h2, 1'b0);
         EXT_PIN[1] <= 1'b1;
         leave();
      end
      mask(1'b1);
      sens(8'h10);
      EXT_GATE_N <= 4'hB;
      @(posedge REF_CLK);
      EXT_PIN[2] <= 1'b0;
      @(posedge REF_CLK);
      EXT_PIN[2] <= 1'b1;
      mask(1'b0);
      tick_end();
      check("gated line", SUSPEND, 1'b0);
      EXT_GATE_N <= 4'hF;
      mask(1'b1);
      sens(8'h00);
      PERIPH_FLAG <= 6'h01;
      mask(1'b0);
      tick_end();
      check("disabled flag", SUSPEND, 1'b0);
      PERIPH_EN <= 6'h3F;
      WAIT_MODE <= 1'b1;
      STOP_MODE <= 1'b1;
      step(3);
      check("wait wake", WAKE_WAIT, 1'b1);
      check("stop wake detector", WAKE_STOP, 1'b0);
      PERIPH_FLAG <= 6'h05;
      step(3);
      check("stop wake overflow", WAKE_STOP, 1'b1);
      WAIT_MODE <= 1'b0;
      STOP_MODE <= 1'b0;
      enter(VIC_SLOT_AVD, 1'b0);
      PERIPH_FLAG <= 6'h04;
      leave();
      enter(VIC_SLOT_AT_OVF, 1'b0);
      PERIPH_FLAG <= 6'h00;
      leave();
      final_report();
   end
endmodule : test_vectored_interrupt_controller
